// ==== design/gray_flags_map.svh ====
// Named constants of the sector flag generator: sector split, reset values and register map.
// Assumes inclusion by bare name from the package and the design files.
`ifndef GRAY_FLAGS_MAP_SVH
`define GRAY_FLAGS_MAP_SVH

`define SECTOR_BITS      4
`define SECTOR_COUNT     16
`define AHEAD_ONE        4'h1
`define AHEAD_TWO        4'h2
`define AHEAD_THREE      4'h3
`define DEPTH_MIN        512
`define DEPTH_MAX        4096
`define DEPTH_DEFAULT    512
`define NEAR_EMPTY_RESET 1'b1
`define NEAR_FULL_RESET  1'b0
`define FULL_RESET       1'b0
`define REG_FLAGS        8'h00
`define REG_INT_STATUS   8'h04
`define REG_INT_MASK     8'h08
`define INT_MASK_RESET   3'h0
`define INT_NEAR_FULL    0
`define INT_FULL         1
`define INT_NEAR_EMPTY   2
`define HTRANS_NONSEQ_BIT 1
`define HSIZE_WORD       3'h2

`endif

// ==== design/gray_flags_pkg.sv ====
// Types and Gray conversion used only by the sector flag generator.
// Assumes the constant header is on the include path.
`include "gray_flags_map.svh"

package gray_flags_pkg;

  typedef logic [`SECTOR_BITS-1:0] sector_t;

  typedef struct packed {
    logic       nearFull;
    logic       full;
    logic       nearEmpty;
  } flags_t;

  typedef struct packed {
    logic       wrClkPrev;
    logic       rdClkPrev;
    sector_t    wSec;
    sector_t    wSecGray;
    logic       halfDly;
    sector_t    wSyncRGray1;
    sector_t    wSyncRGray2;
    logic       afOr;
    logic       afOrPrev;
    sector_t    rSec;
    sector_t    rSecGray;
    sector_t    rSyncWGray1;
    sector_t    rSyncWGray2;
    logic       aeOr;
    logic       aeOrPrev;
    flags_t     flags;
    flags_t     flagsPrev;
    logic [2:0] intStatus;
    logic [2:0] intMask;
    logic       dPhase;
    logic [7:0] dAddr;
    logic [31:0] rdata;
  } state_t;

  function automatic sector_t toGray(input sector_t bin);
    toGray = bin ^ (bin >> 1);
  endfunction : toGray

endpackage : gray_flags_pkg

// ==== design/sync_two_stage.sv ====
// Two-flop synchroniser for inputs arriving from outside the clock domain.
// Assumes the first stage is read only by the second.
`timescale 1ns/1ns
`default_nettype none

module sync_two_stage #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_t;

  sync_t st;
  sync_t next_st;

  initial begin
    if (WIDTH < 1) begin
      $error("sync_two_stage: WIDTH must be at least one");
    end
  end

  always_comb begin
    next_st.stage1 = din;
    next_st.stage2 = st.stage1;
    if (srst) begin
      next_st = '0;
    end
  end

  always_ff @(posedge clock) begin
    st <= next_st;
  end

  assign dout = st.stage2;

endmodule : sync_two_stage

`default_nettype wire

// ==== design/gray_sector_fifo_flags.sv ====
// Sector-based near-full, full and near-empty flag generator for a dual-clock FIFO memory,
// with an AHB-Lite slave for flag status, sticky interrupt events and an interrupt mask.
// Assumes write_clock and read_clock run well below a quarter of clock, and that each
// pointer count is stable from one edge of its own clock to the next.
`timescale 1ns/1ns
`default_nettype none
`include "gray_flags_map.svh"

// Overview of operation
// - Address space split into sixteen equal sectors.
// - Write sector is top four write-count bits.
// - Near-full when read sector is write+1..+3.
// - Three Gray converters for write sector offsets.
// - Any of three matches raises near-full.
// - Near-full clears after two false write periods.
// - Near-empty uses same filter in read domain.
// - Full is near-full with half-sector bit set.
// - Stopped write clock freezes near-full and full.
// - Near-empty when read equals write or write-1.
// - Near-empty sets two to three read periods.
// - Near-full sets in two-three, clears in three-four write periods.
// - Full has near-full latency.
// - Near-empty clears three to four read periods.
// - External flags survive stopped read or write clock.
// - Depths 512, 1K, 2K, 4K words supported.
module gray_sector_fifo_flags #(
  parameter int DEPTH = `DEPTH_DEFAULT
) (
  input  wire logic                     clock,
  input  wire logic                     srst,
  input  wire logic                     write_clock,
  input  wire logic                     read_clock,
  input  wire logic [$clog2(DEPTH)-1:0] write_pointer_count,
  input  wire logic [$clog2(DEPTH)-1:0] read_pointer_count,
  output logic                          near_full_flag,
  output logic                          full_flag,
  output logic                          near_empty_flag,
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic                          hresp,
  output logic [31:0]                   hrdata,
  output logic                          irq
);

  localparam int CW = $clog2(DEPTH);

  initial begin
    if (DEPTH < `DEPTH_MIN || DEPTH > `DEPTH_MAX) begin
      $error("gray_sector_fifo_flags: DEPTH must lie between 512 and 4096 words");
    end
    if ((DEPTH & (DEPTH - 1)) != 0) begin
      $error("gray_sector_fifo_flags: DEPTH must be a power of two");
    end
    if ((DEPTH % `SECTOR_COUNT) != 0) begin
      $error("gray_sector_fifo_flags: DEPTH must split into whole sectors");
    end
  end

  gray_flags_pkg::state_t st;
  gray_flags_pkg::state_t next_st;

  logic [1:0]    clkSync;
  logic [CW-1:0] wCountSync;
  logic [CW-1:0] rCountSync;
  logic          wrTick;
  logic          rdTick;
  logic          matchOne;
  logic          matchTwo;
  logic          matchThree;
  logic          matchAny;
  logic          emptyMatch;
  logic          addrTaken;
  logic [31:0]   readValue;
  gray_flags_pkg::sector_t aheadDist;
  gray_flags_pkg::sector_t behindDist;

  sync_two_stage #(
    .WIDTH (2)
  ) clockSync (
    .clock (clock),
    .srst  (srst),
    .din   ({write_clock, read_clock}),
    .dout  (clkSync)
  );

  sync_two_stage #(
    .WIDTH (2 * CW)
  ) countSync (
    .clock (clock),
    .srst  (srst),
    .din   ({write_pointer_count, read_pointer_count}),
    .dout  ({wCountSync, rCountSync})
  );

  // A write period and a read period are each marked by one rising edge seen on the
  // synchronised clock; with no edge nothing on that side moves.
  assign wrTick = clkSync[1] & ~st.wrClkPrev;
  assign rdTick = clkSync[0] & ~st.rdClkPrev;

  // Near-full comparisons against the synchronised Gray read sector.
  assign matchOne   = st.wSyncRGray2 == gray_flags_pkg::toGray(st.wSec + `AHEAD_ONE);
  assign matchTwo   = st.wSyncRGray2 == gray_flags_pkg::toGray(st.wSec + `AHEAD_TWO);
  assign matchThree = st.wSyncRGray2 == gray_flags_pkg::toGray(st.wSec + `AHEAD_THREE);
  assign matchAny   = matchOne | matchTwo | matchThree;

  // Read equals write-1 is tested as read+1 equals write, so only Gray values cross.
  assign emptyMatch = (st.rSecGray == st.rSyncWGray2) ||
                      (gray_flags_pkg::toGray(st.rSec + `AHEAD_ONE) == st.rSyncWGray2);

  assign addrTaken = hsel & htrans[`HTRANS_NONSEQ_BIT] & hready;

  always_comb begin
    readValue = 32'h0000_0000;
    unique case (haddr[7:0])
      `REG_FLAGS: begin
        readValue[`INT_NEAR_FULL]  = st.flags.nearFull;
        readValue[`INT_FULL]       = st.flags.full;
        readValue[`INT_NEAR_EMPTY] = st.flags.nearEmpty;
      end
      `REG_INT_STATUS: begin
        readValue[2:0] = st.intStatus;
      end
      `REG_INT_MASK: begin
        readValue[2:0] = st.intMask;
      end
      default: begin
        readValue = 32'h0000_0000;
      end
    endcase
  end

  always_comb begin
    next_st           = st;
    next_st.wrClkPrev = clkSync[1];
    next_st.rdClkPrev = clkSync[0];

    if (wrTick) begin
      next_st.wSec        = wCountSync[CW-1 -: `SECTOR_BITS];
      next_st.wSecGray    = gray_flags_pkg::toGray(wCountSync[CW-1 -: `SECTOR_BITS]);
      next_st.halfDly     = wCountSync[CW-1-`SECTOR_BITS];
      next_st.wSyncRGray1 = st.rSecGray;
      next_st.wSyncRGray2 = st.wSyncRGray1;
      next_st.afOr        = matchAny;
      next_st.afOrPrev    = st.afOr;
      next_st.flags.nearFull = st.afOr | st.afOrPrev;
      next_st.flags.full     = (st.afOr | st.afOrPrev) & st.halfDly;
    end

    if (rdTick) begin
      next_st.rSec        = rCountSync[CW-1 -: `SECTOR_BITS];
      next_st.rSecGray    = gray_flags_pkg::toGray(rCountSync[CW-1 -: `SECTOR_BITS]);
      next_st.rSyncWGray1 = st.wSecGray;
      next_st.rSyncWGray2 = st.rSyncWGray1;
      next_st.aeOr        = emptyMatch;
      next_st.aeOrPrev    = st.aeOr;
      next_st.flags.nearEmpty = st.aeOr | st.aeOrPrev;
    end

    // Flag rising edges are sticky events; a read of the status clears them, but an
    // event in the same cycle wins.
    next_st.flagsPrev = st.flags;
    if (addrTaken && !hwrite && haddr[7:0] == `REG_INT_STATUS) begin
      next_st.intStatus = 3'h0;
    end
    if (st.flags.nearFull && !st.flagsPrev.nearFull) begin
      next_st.intStatus[`INT_NEAR_FULL] = 1'b1;
    end
    if (st.flags.full && !st.flagsPrev.full) begin
      next_st.intStatus[`INT_FULL] = 1'b1;
    end
    if (st.flags.nearEmpty && !st.flagsPrev.nearEmpty) begin
      next_st.intStatus[`INT_NEAR_EMPTY] = 1'b1;
    end

    next_st.dPhase = addrTaken && hwrite && hsize == `HSIZE_WORD;
    next_st.dAddr  = haddr[7:0];
    if (addrTaken && !hwrite) begin
      next_st.rdata = readValue;
    end
    if (st.dPhase && st.dAddr == `REG_INT_MASK) begin
      next_st.intMask = hwdata[2:0];
    end

    if (srst) begin
      next_st                 = '0;
      next_st.flags.nearEmpty = `NEAR_EMPTY_RESET;
      next_st.flags.nearFull  = `NEAR_FULL_RESET;
      next_st.flags.full      = `FULL_RESET;
      next_st.flagsPrev       = next_st.flags;
      // The empty filter starts full, so near-empty holds through the first read edges.
      next_st.aeOr            = `NEAR_EMPTY_RESET;
      next_st.aeOrPrev        = `NEAR_EMPTY_RESET;
      next_st.intMask         = `INT_MASK_RESET;
    end
  end

  always_ff @(posedge clock) begin
    st <= next_st;
  end

  assign near_full_flag  = st.flags.nearFull;
  assign full_flag       = st.flags.full;
  assign near_empty_flag = st.flags.nearEmpty;
  assign hreadyout       = 1'b1;
  assign hresp           = 1'b0;
  assign hrdata          = st.rdata;
  assign irq             = |(st.intStatus & st.intMask);

  // Binary value of a Gray sector, for the checks below.
  function automatic gray_flags_pkg::sector_t fromGray(input gray_flags_pkg::sector_t gray);
    fromGray = gray ^ (gray >> 1) ^ (gray >> 2) ^ (gray >> 3);
  endfunction : fromGray

  // Sector distances in binary; they are read only by the checks.
  assign aheadDist  = fromGray(st.wSyncRGray2) - st.wSec;
  assign behindDist = st.rSec - fromGray(st.rSyncWGray2);

  // Checks on the flag paths and the event logic.

  a_reset_flags: assert property (@(posedge clock)
    srst |=> (near_empty_flag && !near_full_flag && !full_flag))
    else $error("Flags wrong after reset.");

  a_freeze_write_side: assert property (@(posedge clock) disable iff (srst)
    !wrTick |=> ($stable(near_full_flag) && $stable(full_flag)))
    else $error("Write-side flag moved without a write clock edge.");

  a_freeze_read_side: assert property (@(posedge clock) disable iff (srst)
    !rdTick |=> $stable(near_empty_flag))
    else $error("Near-empty moved without a read clock edge.");

  a_full_needs_near: assert property (@(posedge clock) disable iff (srst)
    full_flag |-> near_full_flag)
    else $error("Full without near-full.");

  a_near_full_filter: assert property (@(posedge clock) disable iff (srst)
    $fell(near_full_flag) |-> $past(!st.afOr && !st.afOrPrev))
    else $error("Near-full cleared without two false write periods.");

  a_near_empty_filter: assert property (@(posedge clock) disable iff (srst)
    $fell(near_empty_flag) |-> $past(!st.aeOr && !st.aeOrPrev))
    else $error("Near-empty cleared without two false read periods.");

  a_near_full_set: assert property (@(posedge clock) disable iff (srst)
    (wrTick && matchAny) |=> (!wrTick)[*1] or st.afOr)
    else $error("Sector match not captured on write edge.");

  a_match_to_flag: assert property (@(posedge clock) disable iff (srst)
    (st.afOr && wrTick) |=> near_full_flag)
    else $error("Near-full not raised after a captured match.");

  a_empty_to_flag: assert property (@(posedge clock) disable iff (srst)
    (st.aeOr && rdTick) |=> near_empty_flag)
    else $error("Near-empty not raised after a captured match.");

  a_full_latency: assert property (@(posedge clock) disable iff (srst)
    (st.afOr && st.halfDly && wrTick) |=> full_flag)
    else $error("Full not raised with near-full latency.");

  a_read_gray_sync: assert property (@(posedge clock) disable iff (srst)
    wrTick |=> (st.wSyncRGray2 == $past(st.wSyncRGray1)))
    else $error("Read sector Gray skipped a write stage.");

  a_event_sticky: assert property (@(posedge clock) disable iff (srst)
    $rose(near_full_flag) |=> st.intStatus[`INT_NEAR_FULL])
    else $error("Near-full event not recorded.");

  a_write_sector_take: assert property (@(posedge clock) disable iff (srst)
    wrTick |=> (st.wSec == $past(wCountSync[CW-1 -: `SECTOR_BITS])))
    else $error("Write sector not taken from the top count bits.");

  a_half_sector_take: assert property (@(posedge clock) disable iff (srst)
    wrTick |=> (st.halfDly == $past(wCountSync[CW-1-`SECTOR_BITS])))
    else $error("Half-sector bit not taken on a write edge.");

  a_read_sector_take: assert property (@(posedge clock) disable iff (srst)
    rdTick |=> (fromGray(st.rSecGray) == $past(rCountSync[CW-1 -: `SECTOR_BITS])))
    else $error("Gray read sector does not match the read count.");

  a_write_gray_sync: assert property (@(posedge clock) disable iff (srst)
    rdTick |=> (st.rSyncWGray2 == $past(st.rSyncWGray1)))
    else $error("Write sector Gray skipped a read stage.");

  a_ahead_window: assert property (@(posedge clock) disable iff (srst)
    matchAny == (aheadDist inside {`AHEAD_ONE, `AHEAD_TWO, `AHEAD_THREE}))
    else $error("Near-full match outside one to three sectors ahead.");

  a_empty_window: assert property (@(posedge clock) disable iff (srst)
    emptyMatch == ((behindDist == '0) || (behindDist == '1)))
    else $error("Near-empty match outside equal or one sector behind.");

  a_near_full_clear: assert property (@(posedge clock) disable iff (srst)
    (wrTick && !st.afOr && !st.afOrPrev) |=> !near_full_flag)
    else $error("Near-full held after two false write periods.");

  a_full_clear: assert property (@(posedge clock) disable iff (srst)
    (wrTick && !st.halfDly) |=> !full_flag)
    else $error("Full held without the half-sector bit.");

  a_empty_clear: assert property (@(posedge clock) disable iff (srst)
    (rdTick && !st.aeOr && !st.aeOrPrev) |=> !near_empty_flag)
    else $error("Near-empty held after two false read periods.");

  a_mask_write: assert property (@(posedge clock) disable iff (srst)
    (st.dPhase && st.dAddr == `REG_INT_MASK) |=> (st.intMask == $past(hwdata[2:0])))
    else $error("Mask write did not land.");

  a_read_data: assert property (@(posedge clock) disable iff (srst)
    (addrTaken && !hwrite) |=> (hrdata == $past(readValue)))
    else $error("Read data not loaded at the address phase.");

  a_bus_okay: assert property (@(posedge clock) disable iff (srst)
    hreadyout && !hresp)
    else $error("Bus slave not ready or not OKAY.");

  c_near_full_rise: cover property (@(posedge clock) disable iff (srst)
    $rose(near_full_flag));

  c_full_rise: cover property (@(posedge clock) disable iff (srst)
    $rose(full_flag));

  c_near_empty_fall: cover property (@(posedge clock) disable iff (srst)
    $fell(near_empty_flag));

  c_irq_raised: cover property (@(posedge clock) disable iff (srst)
    $rose(irq));

  c_near_full_fall: cover property (@(posedge clock) disable iff (srst)
    $fell(near_full_flag));

endmodule : gray_sector_fifo_flags

`default_nettype wire

// ==== dv/fifo_counter_model.sv ====
// Behavioural model of the dual-clock FIFO memory: its write and read clocks and pointer counts.
// Assumes the bench calls its tasks; a clock that no task is running stands still.
`timescale 1ns/1ns
`default_nettype none

module fifo_counter_model #(
  parameter int CW = 9
) (
  output logic          write_clock,
  output logic          read_clock,
  output logic [CW-1:0] write_pointer_count,
  output logic [CW-1:0] read_pointer_count
);
  initial begin
    write_clock = 1'h0;
    read_clock = 1'h0;
    write_pointer_count = '0;
    read_pointer_count = '0;
  end

  // Counts move just after their own clock rises, so they are stable at the next rise.
  // Each clock rises 10 ns into a cycle, well clear of the bench clock's rising edge.
  task automatic wrCycles(input int n, input bit inc);
    repeat (n) begin
      #10;
      write_clock = 1'h1;
      #3;
      if (inc) begin
        write_pointer_count = write_pointer_count + 1'h1;
      end
      #167;
      write_clock = 1'h0;
      #180;
    end
  endtask : wrCycles

  task automatic rdCycles(input int n, input bit inc);
    repeat (n) begin
      #10;
      read_clock = 1'h1;
      #3;
      if (inc) begin
        read_pointer_count = read_pointer_count + 1'h1;
      end
      #127;
      read_clock = 1'h0;
      #140;
    end
  endtask : rdCycles
endmodule : fifo_counter_model
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench of the sector flag generator, driving its registers over AHB-Lite.
// Assumes the FIFO counter model supplies both FIFO clocks and both pointer counts.
`timescale 1ns/1ns
`default_nettype none
`include "gray_flags_map.svh"

module tb;
  localparam int DEPTH = 512;
  localparam int CW = $clog2(DEPTH);

  logic          clock;
  logic          srst;
  logic          write_clock;
  logic          read_clock;
  logic [CW-1:0] wpc;
  logic [CW-1:0] rpc;
  logic          near_full_flag;
  logic          full_flag;
  logic          near_empty_flag;
  logic          hsel;
  logic [31:0]   haddr;
  logic [1:0]    htrans;
  logic          hwrite;
  logic [2:0]    hsize;
  logic [31:0]   hwdata;
  logic          hready;
  logic          hreadyout;
  logic          hresp;
  logic [31:0]   hrdata;
  logic          irq;
  int            nErrors = 0;
  int            checks = 0;

  assign hready = hreadyout;

  gray_sector_fifo_flags #(.DEPTH(DEPTH)) i_gray_sector_fifo_flags (
    .clock(clock), .srst(srst), .write_clock(write_clock), .read_clock(read_clock),
    .write_pointer_count(wpc), .read_pointer_count(rpc), .near_full_flag(near_full_flag),
    .full_flag(full_flag), .near_empty_flag(near_empty_flag), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq));

  fifo_counter_model #(.CW(CW)) i_fifo_counter_model (
    .write_clock(write_clock), .read_clock(read_clock),
    .write_pointer_count(wpc), .read_pointer_count(rpc));

  initial begin
    clock = 1'h0;
    forever #20 clock = ~clock;
  end

  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, nErrors);
    if (nErrors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      nErrors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic waitReady();
    int n;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (hreadyout !== 1'h1 && n < 20);
    if (hreadyout !== 1'h1) begin
      nErrors++;
      give_verdict();
    end
  endtask : waitReady

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge clock);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= `HSIZE_WORD;
    waitReady();
    htrans <= 2'h0;
    hsel <= 1'h0;
    hwdata <= wd;
    waitReady();
    rd = hrdata;
  endtask : ahb

  task automatic readCheck(input logic [7:0] a, input logic [31:0] e, input string name);
    logic [31:0] rd;
    ahb(1'h0, a, 32'h0, rd);
    check(name, rd, e);
  endtask : readCheck

  // Flags expected from the two counts: bit 0 near full, bit 1 full, bit 2 near empty.
  function automatic logic [2:0] expFlags(input logic [CW-1:0] wc, input logic [CW-1:0] rc);
    logic [3:0] ws;
    logic [3:0] rs;
    logic       nf;
    ws = wc[CW-1 -: 4];
    rs = rc[CW-1 -: 4];
    nf = (rs == ws + 4'h1) || (rs == ws + 4'h2) || (rs == ws + 4'h3);
    return {(rs == ws) || (rs == ws - 4'h1), nf && wc[CW-5], nf};
  endfunction : expFlags

  // Both FIFO clocks run idle long enough for every flag latency to pass.
  task automatic settle();
    fork
      i_fifo_counter_model.wrCycles(8, 1'b0);
      i_fifo_counter_model.rdCycles(8, 1'b0);
    join
  endtask : settle

  task automatic checkFlags();
    logic [31:0] e;
    e = {29'h0, expFlags(wpc, rpc)};
    check("flag pins", {29'h0, near_empty_flag, full_flag, near_full_flag}, e);
    readCheck(`REG_FLAGS, e, "flag register");
  endtask : checkFlags

  initial begin
    int          k;
    logic [31:0] rdata;
    srst = 1'h1;
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h0;
    hwdata = 32'h0;
    repeat (20) @(posedge clock);
    srst <= 1'h0;
    @(posedge clock);
    check("reset pins", {28'h0, irq, near_empty_flag, full_flag, near_full_flag}, 32'h4);
    check("bus response", {30'h0, hreadyout, hresp}, 32'h2);
    readCheck(`REG_INT_MASK, 32'h0, "mask reset");
    readCheck(8'h0C, 32'h0, "unmapped read");
    ahb(1'h0, `REG_INT_STATUS, 32'h0, rdata);
    // The write count walks every sector distance in half-sector steps.
    for (k = 0; k < 30; k++) begin
      i_fifo_counter_model.wrCycles(16, 1'b1);
      settle();
      checkFlags();
    end
    check("irq masked", irq, 1'h0);
    readCheck(`REG_INT_STATUS, 32'h3, "events after sweep");
    readCheck(`REG_INT_STATUS, 32'h0, "events cleared");
    // Reads cross four sectors while the write clock stands still.
    i_fifo_counter_model.rdCycles(128, 1'b1);
    check("frozen near full", {full_flag, near_full_flag}, 2'h1);
    settle();
    checkFlags();
    ahb(1'h1, `REG_INT_MASK, 32'h7, rdata);
    ahb(1'h0, `REG_INT_STATUS, 32'h0, rdata);
    check("irq idle", irq, 1'h0);
    i_fifo_counter_model.wrCycles(64, 1'b1);
    settle();
    checkFlags();
    check("irq raised", irq, 1'h1);
    readCheck(`REG_INT_STATUS, 32'h1, "near full event");
    check("irq after clear", irq, 1'h0);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
